// File: core/mpsp_port.sv
// Line-side port: serial encoder/decoder path and five-bit symbol path.
// Assumes link clocks come from the line device; core runs on ref_clk.
// Behaviour
// RULE_01 - Serial receive data arrives aligned to the supplied receive clock.
// RULE_02 - Partner raises receive enable while a frame is on the cable.
// RULE_03 - Receive enable is synchronised before frame logic uses it.
// RULE_04 - Partner keeps the serial transmit clock running, even in reset.
// RULE_05 - Serial transmit data is driven on the supplied transmit clock.
// RULE_06 - Serial transmit enable stays high through a whole transmission.
// RULE_07 - Symbol lock output is high while the descrambler is locked.
// RULE_08 - In symbol mode, receive symbols are five bits: bit4 plus nibble.
// RULE_09 - Partner drives receive symbols aligned to the symbol receive clock.
// RULE_10 - In symbol mode, transmit symbols are five bits: bit4 plus nibble.
// RULE_11 - Transmit symbol outputs change on rising symbol transmit clock.
// RULE_12 - Receive clock may stop between frames; logic must not need it.
// RULE_13 - Collision input is synchronised before use.
// RULE_14 - In symbol mode, nibble transmit enable reflects transmit activity.
// RULE_15 - Traffic uses serial or symbol path per mode, never both.
`default_nettype none
module mpsp_port
    import mpsp_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             pcs_mode_select,
    // Core transmit stream, one bit (serial) or symbol per link beat
    input  wire logic             tx_active,
    input  wire logic             tx_bit,
    input  wire logic [SYM_W-1:0] tx_sym,
    // Serial link
    input  wire logic             srl_rclk,
    input  wire logic             srl_rxd,
    input  wire logic             srl_rxen,
    input  wire logic             srl_clsn,
    input  wire logic             srl_tclk,
    output logic                  srl_txd,
    output logic                  srl_txen,
    // Symbol link
    input  wire logic             sym_rclk,
    input  wire logic             sym_tclk,
    input  wire logic [NIB_W-1:0] sym_rxd_lo,
    input  wire logic             sym_rxd_hi,
    output logic [NIB_W-1:0]      sym_txd_lo,
    output logic                  sym_txd_hi,
    output logic                  mii_txen,
    output logic                  sym_link,
    // Core side receive data and status
    output logic                  rx_bit,
    output logic [SYM_W-1:0]      rx_sym,
    output logic                  rx_carrier,
    output logic                  rx_collision
);
    import mpsp_pkg::*;

    function automatic logic [3:0] sat_inc(input logic [3:0] v);
        sat_inc = (v == LOCK_CNT) ? v : v + CNT_ONE;
    endfunction

    // Core domain: level inputs pass two flops before use
    mpsp_sync_if sif ();
    assign sif.async_in = {srl_clsn, srl_rxen};

    mpsp_sync2 u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .bus     (sif)
    );

    // Core-side mode/active levels resynchronised into each transmit link clock
    typedef struct packed {
        logic [1:0]     mode_s;
        logic [1:0]     act_s;
        mpsp_tx_state_t st;
        logic           txd;
        logic           txen;
    } mpsp_stx_t;

    typedef struct packed {
        logic [1:0]       mode_s;
        logic [1:0]       act_s;
        logic [SYM_W-1:0] sym;
        logic             txen;
    } mpsp_ytx_t;

    typedef struct packed {
        logic             bit_q;
    } mpsp_srx_t;

    typedef struct packed {
        logic [SYM_W-1:0] sym;
        logic [3:0]       idle_cnt;
        logic             locked;
    } mpsp_yrx_t;

    typedef struct packed {
        logic [1:0]       lock_s;
        logic             carrier;
        logic             collision;
    } mpsp_core_t;

    mpsp_stx_t  stx_reg, stx_next;
    mpsp_ytx_t  ytx_reg, ytx_next;
    mpsp_srx_t  srx_reg, srx_next;
    mpsp_yrx_t  yrx_reg, yrx_next;
    mpsp_core_t cor_reg, cor_next;

    // Serial transmit on the partner's free-running clock
    always_comb begin
        stx_next        = stx_reg;
        stx_next.mode_s = {stx_reg.mode_s[0], pcs_mode_select};
        stx_next.act_s  = {stx_reg.act_s[0], tx_active};
        case (stx_reg.st)
            MPSP_ST_IDLE: begin
                // Serial path stays quiet in symbol mode
                if (stx_reg.act_s[1] && !stx_reg.mode_s[1]) begin // RULE_15
                    stx_next.st = MPSP_ST_SEND;
                end
            end
            MPSP_ST_SEND: begin
                if (!stx_reg.act_s[1] || stx_reg.mode_s[1]) begin
                    stx_next.st = MPSP_ST_IDLE;
                end
            end
            default: stx_next.st = MPSP_ST_IDLE;
        endcase
        stx_next.txen = (stx_next.st == MPSP_ST_SEND); // RULE_06
        stx_next.txd  = stx_next.txen ? tx_bit : 1'b0; // RULE_05
    end

    // Reset is safe here: the transmit clock runs even during reset
    always_ff @(posedge srl_tclk or posedge sys_rst) begin
        if (sys_rst) begin
            stx_reg <= '{mode_s: SYNC_RST, act_s: SYNC_RST,
                         st: MPSP_ST_IDLE, txd: 1'b0, txen: 1'b0};
        end else begin
            stx_reg <= stx_next;
        end
    end

    assign srl_txd  = stx_reg.txd;
    assign srl_txen = stx_reg.txen;

    // Symbol transmit on rising symbol transmit clock
    always_comb begin
        ytx_next        = ytx_reg;
        ytx_next.mode_s = {ytx_reg.mode_s[0], pcs_mode_select};
        ytx_next.act_s  = {ytx_reg.act_s[0], tx_active};
        ytx_next.txen   = ytx_reg.mode_s[1] && ytx_reg.act_s[1]; // RULE_14
        if (!ytx_reg.mode_s[1]) begin
            ytx_next.sym = SYM_ZERO; // RULE_15
        end else if (ytx_reg.act_s[1]) begin
            ytx_next.sym = tx_sym; // RULE_10 RULE_11
        end else begin
            ytx_next.sym = SYM_IDLE;
        end
    end

    always_ff @(posedge sym_tclk or posedge sys_rst) begin
        if (sys_rst) begin
            ytx_reg <= '{mode_s: SYNC_RST, act_s: SYNC_RST,
                         sym: SYM_ZERO, txen: 1'b0};
        end else begin
            ytx_reg <= ytx_next;
        end
    end

    assign sym_txd_hi = ytx_reg.sym[SYM_MSB]; // RULE_10
    assign sym_txd_lo = ytx_reg.sym[NIB_W-1:0];
    assign mii_txen   = ytx_reg.txen;

    // Serial receive data sampled on the recovered clock
    always_comb begin
        srx_next       = srx_reg;
        srx_next.bit_q = srl_rxd; // RULE_01
    end

    // Clock may halt when idle; held value is harmless
    always_ff @(posedge srl_rclk or posedge sys_rst) begin // RULE_12
        if (sys_rst) begin
            srx_reg <= '{bit_q: 1'b0};
        end else begin
            srx_reg <= srx_next;
        end
    end

    // Symbol receive: five parallel bits, lock on idle run
    always_comb begin
        yrx_next     = yrx_reg;
        yrx_next.sym = {sym_rxd_hi, sym_rxd_lo}; // RULE_08 RULE_09
        if (yrx_reg.sym == SYM_IDLE) begin
            yrx_next.idle_cnt = sat_inc(yrx_reg.idle_cnt);
        end else if (!yrx_reg.locked) begin
            yrx_next.idle_cnt = CNT_ZERO;
        end
        yrx_next.locked = (yrx_next.idle_cnt == LOCK_CNT); // RULE_07
    end

    always_ff @(posedge sym_rclk or posedge sys_rst) begin
        if (sys_rst) begin
            yrx_reg <= '{sym: SYM_ZERO, idle_cnt: CNT_ZERO, locked: 1'b0};
        end else begin
            yrx_reg <= yrx_next;
        end
    end

    assign sym_link = yrx_reg.locked; // RULE_07

    // Core domain status; carrier and collision gated by path in use
    always_comb begin
        cor_next           = cor_reg;
        cor_next.lock_s    = {cor_reg.lock_s[0], yrx_reg.locked};
        cor_next.carrier   = pcs_mode_select ? cor_reg.lock_s[1]
                                             : sif.sync_out[0]; // RULE_03
        cor_next.collision = !pcs_mode_select
                             && sif.sync_out[1]; // RULE_13
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cor_reg <= '{lock_s: SYNC_RST, carrier: 1'b0, collision: 1'b0};
        end else begin
            cor_reg <= cor_next;
        end
    end

    // Data outputs stay in their link clock domain
    assign rx_bit       = pcs_mode_select ? 1'b0 : srx_reg.bit_q; // RULE_15
    assign rx_sym       = pcs_mode_select ? yrx_reg.sym : SYM_ZERO;
    assign rx_carrier   = cor_reg.carrier;
    assign rx_collision = cor_reg.collision;
endmodule
`default_nettype wire

// File: core/mpsp_pkg.sv
// Shared constants and types of the serial/symbol line port.
// Assumes one core clock plus link clocks supplied by the line device.
`default_nettype none
package mpsp_pkg;
    localparam int SYM_W    = 5;
    localparam int NIB_W    = 4;
    localparam int SYM_MSB  = 4;
    localparam int SYNC_LEN = 2;
    localparam logic [1:0] SYNC_RST = 2'h0;
    localparam logic [4:0] SYM_IDLE = 5'h1f;
    localparam logic [4:0] SYM_ZERO = 5'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    // Descrambler lock: this many consecutive idle symbols in a row
    localparam logic [3:0] LOCK_CNT = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE  = 4'h1;

    typedef enum logic [0:0] {
        MPSP_ST_IDLE = 1'b0,
        MPSP_ST_SEND = 1'b1
    } mpsp_tx_state_t;
endpackage
`default_nettype wire

// File: core/mpsp_sync_if.sv
// Carrier between the port top and its two-flop synchroniser.
// Assumes the synchroniser runs on the core clock.
`default_nettype none
interface mpsp_sync_if;
    logic [1:0] async_in;
    logic [1:0] sync_out;
    modport user (output async_in, input sync_out);
    modport sync (input async_in, output sync_out);
endinterface
`default_nettype wire

// File: core/mpsp_sync2.sv
// Two-flop level synchroniser for two bits.
// Assumes inputs may change at any time relative to ref_clk.
`default_nettype none
module mpsp_sync2
    import mpsp_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    mpsp_sync_if.sync bus
);
    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] stable;
    } mpsp_sync_state_t;

    mpsp_sync_state_t st_reg;
    mpsp_sync_state_t st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.meta   = bus.async_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '{meta: SYNC_RST, stable: SYNC_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.sync_out = st_reg.stable;
endmodule
`default_nettype wire

// File: test/mpsp_port_props.sv
// Pin checker of the line port; assumes link clocks from the line device.
`default_nettype none
module mpsp_port_props (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       pcs_mode_select,
    input wire logic       tx_active,
    input wire logic       tx_bit,
    input wire logic [4:0] tx_sym,
    input wire logic       srl_rxen,
    input wire logic       srl_clsn,
    input wire logic       srl_tclk,
    input wire logic       srl_txd,
    input wire logic       srl_txen,
    input wire logic       sym_rclk,
    input wire logic       sym_tclk,
    input wire logic [3:0] sym_rxd_lo,
    input wire logic       sym_rxd_hi,
    input wire logic [3:0] sym_txd_lo,
    input wire logic       sym_txd_hi,
    input wire logic       mii_txen,
    input wire logic       sym_link,
    input wire logic       rx_carrier,
    input wire logic       rx_collision
);
    a_serial_quiet: assert property (@(posedge srl_tclk)
        disable iff (sys_rst) pcs_mode_select [*4] |-> !srl_txen && !srl_txd)
        else $error("serial busy");
    a_txen_start: assert property (@(posedge srl_tclk)
        disable iff (sys_rst) (tx_active && !pcs_mode_select) [*5] |-> srl_txen)
        else $error("txen missing");
    a_txd_data: assert property (@(posedge srl_tclk)
        disable iff (sys_rst) srl_txen && $past(srl_txen)
        |-> srl_txd == $past(tx_bit)) else $error("txd wrong");
    a_sym_data: assert property (@(posedge sym_tclk)
        disable iff (sys_rst) mii_txen && $past(mii_txen)
        |-> {sym_txd_hi, sym_txd_lo} == $past(tx_sym)) else $error("sym wrong");
    a_sym_idle: assert property (@(posedge sym_tclk)
        disable iff (sys_rst) (pcs_mode_select && !tx_active) [*4]
        |-> {sym_txd_hi, sym_txd_lo} == 5'h1f && !mii_txen) else $error("idle");
    a_lock_set: assert property (@(posedge sym_rclk)
        disable iff (sys_rst) ({sym_rxd_hi, sym_rxd_lo} == 5'h1f) [*8]
        |-> ##[1:2] sym_link) else $error("no lock");
    a_carrier_sync: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (!pcs_mode_select && srl_rxen) [*4] |-> rx_carrier)
        else $error("no carrier");
    a_clsn_sync: assert property (@(posedge ref_clk)
        disable iff (sys_rst) (!pcs_mode_select && srl_clsn) [*4]
        |-> rx_collision) else $error("no collision");
endmodule
bind mpsp_port mpsp_port_props u_mpsp_port_props (.*);
`default_nettype wire

// File: test/mpsp_line_model.sv
// Line device model: link clocks, serial frames, symbols; bench gives levels.
`default_nettype none
module mpsp_line_model (
    input  wire logic       rx_frame,
    input  wire logic       sym_idle,
    output logic            srl_rclk,
    output logic            srl_rxd,
    output logic            srl_rxen,
    output logic            srl_tclk,
    output logic            sym_rclk,
    output logic            sym_tclk,
    output logic [3:0]      sym_rxd_lo,
    output logic            sym_rxd_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       lclk = 1'b0;
    logic       gate = 1'b0;
    logic [4:0] sym  = 5'h0a;
    always #24 lclk = ~lclk;
    assign {srl_tclk, sym_tclk, sym_rclk} = {3{lclk}};
    assign srl_rclk = lclk & gate;
    assign srl_rxen = gate;
    assign srl_rxd = sym[0];
    assign {sym_rxd_hi, sym_rxd_lo} = sym;
    // Gate moves on the low phase so no clock pulse is clipped
    always @(negedge lclk) begin
        gate <= rx_frame;
        sym <= sym_idle ? 5'h1f : (sym == 5'h0a ? 5'h15 : 5'h0a);
    end
endmodule
`default_nettype wire

// File: test/mpsp_port_tb_top.sv
// Line port bench: reset check, then transmit table, status and lock cases.
`default_nettype none
module mpsp_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       pcs_mode_select = 1'b0;
    logic       tx_active = 1'b0;
    logic       tx_bit = 1'b0;
    logic [4:0] tx_sym = 5'h00;
    logic       srl_clsn = 1'b0;
    logic       rx_frame = 1'b0;
    logic       sym_idle = 1'b0;
    logic       srl_rclk, srl_rxd, srl_rxen, srl_tclk, srl_txd, srl_txen;
    logic       sym_rclk, sym_tclk, sym_rxd_hi, sym_txd_hi, mii_txen, sym_link;
    logic       rx_bit, rx_carrier, rx_collision;
    logic [3:0] sym_rxd_lo, sym_txd_lo;
    logic [4:0] rx_sym;
    int         n_errors = 0;
    int         total_checks = 0;
    // {mode, active, bit, symbol} then {txen, txd, nibble txen, symbol}
    logic [15:0] rows [6] = '{16'h0000, 16'h60c0, 16'h801f, 16'hca2a,
                              16'hd535, 16'h4080};
    wire logic [7:0] tx_pins = {srl_txen, srl_txd, mii_txen, sym_txd_hi,
                                sym_txd_lo};
    always #2.5 ref_clk = ~ref_clk;
    mpsp_port u_mpsp_port (.*);
    mpsp_line_model u_mpsp_line_model (.*);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        give_verdict();
    end
    // Reset is asynchronous, so eight core cycles clear every link flop
    initial begin
        repeat (8) @(negedge ref_clk);
        chk({srl_txen, mii_txen, sym_link, rx_carrier, 4'h0}, 8'h00);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            {pcs_mode_select, tx_active, tx_bit, tx_sym} = rows[i][15:8];
            repeat (60) @(negedge ref_clk);
            chk(tx_pins, rows[i][7:0]);
        end
        {pcs_mode_select, tx_active, rx_frame, srl_clsn} = 4'h3;
        repeat (60) @(negedge ref_clk);
        chk({5'h00, sym_link, rx_carrier, rx_collision}, 8'h03);
        // Serial receive bit is captured on the gated clock's rising edge
        @(posedge srl_rclk);
        @(negedge ref_clk);
        chk({7'h00, rx_bit}, {7'h00, srl_rxd});
        {rx_frame, srl_clsn} = 2'h0;
        repeat (60) @(negedge ref_clk);
        chk({5'h00, sym_link, rx_carrier, rx_collision}, 8'h00);
        {pcs_mode_select, sym_idle} = 2'h3;
        repeat (120) @(negedge ref_clk);
        chk({sym_link, rx_carrier, 1'b0, rx_sym}, 8'hdf);
        sym_idle = 1'b0;
        repeat (40) @(negedge ref_clk);
        chk({sym_link, rx_bit, 6'h00}, 8'h80);
        give_verdict();
    end
endmodule
`default_nettype wire
